// ===== profile_slot.sv
`timescale 1ns/1ps

module profile_slot
#(
    parameter logic [7:0] RESET_VALUE = 8'h00
)
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic uvlo_clear_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    output vid_profile_pkg::profile_type value_out
);

    logic [7:0] value_reg;
    logic [7:0] value_next;

    // Undervoltage lockout beats any write in the same cycle, since the
    // write could not be trusted while a supply is low.
    always_comb
    begin
        value_next = value_reg;
        if (uvlo_clear_in)
        begin
            value_next = RESET_VALUE;
        end
        else if (wr_en_in)
        begin
            value_next = wr_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            value_reg <= RESET_VALUE;
        end
        else
        begin
            value_reg <= value_next;
        end
    end

    assign value_out.forced_pwm = value_reg[vid_profile_pkg::BIT_FORCED_PWM];
    assign value_out.clock_lock_en = value_reg[vid_profile_pkg::BIT_CLOCK_LOCK_EN];
    assign value_out.voltage_code =
        value_reg[vid_profile_pkg::VOLTAGE_CODE_MSB:vid_profile_pkg::VOLTAGE_CODE_LSB];

endmodule

// ===== test_vid_mode_voltage_regs.sv
`timescale 1ns/1ps

module test_vid_mode_voltage_regs;
    logic clock_in;
    logic nrst_in;
    logic vdd_uvlo;
    logic main_uvlo;
    logic sel_low;
    logic sel_high;
    vid_profile_pkg::byte_cmd_type cmd;
    logic [7:0] rd_data;
    logic [7:0] pointer;
    vid_profile_pkg::profile_type active;
    vid_profile_pkg::slot_sel_type slot;
    logic uvlo_active;
    int mismatches;
    int cmp_count;
    logic [7:0] rst_tab [5] = '{8'hB4, 8'h1E, 8'hB0, 8'h9E, 8'h00};

    vid_host_model host (.clock_in(clock_in), .cmd_out(cmd), .sel_low_out(sel_low), .sel_high_out(sel_high));
    vid_mode_voltage_regs DUT (.clock_in(clock_in), .nrst_in(nrst_in), .cmd_in(cmd),
        .profile_select_low_in(sel_low), .profile_select_high_in(sel_high), .vdd_uvlo_in(vdd_uvlo),
        .main_power_input_uvlo_in(main_uvlo), .rd_data_out(rd_data), .pointer_out(pointer),
        .active_profile_out(active), .active_slot_out(slot), .uvlo_active_out(uvlo_active));

    initial
    begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) host.send(3'b000, 8'h00);
    endtask

    task automatic read_at(input logic [7:0] p, input logic [7:0] exp);
        host.send(3'b100, p);
        idle(2);
        #1 check(rd_data, exp);
    endtask

    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        mismatches = 0;
        cmp_count = 0;
        nrst_in = 1'b0;
        vdd_uvlo = 1'b0;
        main_uvlo = 1'b0;
        repeat (5) @(posedge clock_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 5; i++)
            read_at(8'(i), rst_tab[i]);
        for (int i = 0; i < 4; i++)
        begin
            host.pins(2'(i));
            idle(4);
            #1 check(active, rst_tab[i]);
            check({6'h00, slot}, 8'(i));
        end
        host.pins(2'b01);
        host.send(3'b100, 8'h01);
        host.send(3'b010, 8'hC5);
        host.send(3'b010, 8'h7F);
        idle(1);
        #1 check(pointer, 8'h03);
        check(active, 8'hC5);
        check({2'b00, active.voltage_code}, 8'h05);
        check({6'h00, active.forced_pwm, active.clock_lock_en}, 8'h03);
        read_at(8'h01, 8'hC5);
        host.send(3'b001, 8'h00);
        idle(2);
        #1 check(rd_data, 8'h7F);
        host.pins(2'b10);
        idle(4);
        #1 check(active, 8'h7F);
        // A pointer load beside a write must drop the write, and a write off the map still wraps the pointer.
        host.send(3'b110, 8'hFF);
        host.send(3'b010, 8'h5A);
        idle(1);
        #1 check(pointer, 8'h00);
        check(active, 8'h7F);
        // Each supply's lockout is tried on its own, with fresh data in both slots.
        for (int i = 0; i < 2; i++)
        begin
            host.send(3'b100, 8'h01);
            host.send(3'b010, 8'h3C);
            host.send(3'b010, 8'h3C);
            // Supplies stay good two more cycles so the write into the active slot is seen applied.
            idle(2);
            #1 check(active, 8'h3C);
            idle(1);
            if (i == 0)
                vdd_uvlo <= 1'b1;
            else
                main_uvlo <= 1'b1;
            idle(4);
            #1 check({7'h00, uvlo_active}, 8'h01);
            host.send(3'b010, 8'h11);
            idle(1);
            vdd_uvlo <= 1'b0;
            main_uvlo <= 1'b0;
            idle(4);
            read_at(8'h01, 8'h1E);
            read_at(8'h00, 8'hB4);
            check(active, 8'hB0);
        end
        print_verdict();
    end

    initial
    begin
        #100_000;
        mismatches++;
        print_verdict();
    end
endmodule

// ===== vid_host_model.sv
`timescale 1ns/1ps

module vid_host_model
(
    input wire logic clock_in,
    output vid_profile_pkg::byte_cmd_type cmd_out,
    output logic sel_low_out,
    output logic sel_high_out
);
    initial
    begin
        cmd_out = '0;
        sel_low_out = 1'b0;
        sel_high_out = 1'b0;
    end

    // One byte per strobe; callers chain sends for back-to-back bursts.
    task automatic send(input logic [2:0] kind, input logic [7:0] data);
        @(posedge clock_in);
        cmd_out <= {kind, data};
    endtask

    task automatic pins(input logic [1:0] high_low);
        @(posedge clock_in);
        {sel_high_out, sel_low_out} <= high_low;
    endtask
endmodule

// ===== vid_mode_voltage_regs.sv
`timescale 1ns/1ps


module vid_mode_voltage_regs
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input vid_profile_pkg::byte_cmd_type cmd_in,
    input wire logic profile_select_low_in,
    input wire logic profile_select_high_in,
    input wire logic vdd_uvlo_in,
    input wire logic main_power_input_uvlo_in,
    output logic [7:0] rd_data_out,
    output logic [7:0] pointer_out,
    output vid_profile_pkg::profile_type active_profile_out,
    output vid_profile_pkg::slot_sel_type active_slot_out,
    output logic uvlo_active_out
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Bit order everywhere: {vdd, main input, select high, select low}.
    logic [3:0] pins_meta_reg;
    logic [3:0] pins_meta_next;
    logic [3:0] pins_sync_reg;
    logic [3:0] pins_sync_next;

    always_comb
    begin
        pins_meta_next = {vdd_uvlo_in, main_power_input_uvlo_in,
                          profile_select_high_in, profile_select_low_in};
        pins_sync_next = pins_meta_reg;
    end

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pins_meta_reg <= 4'h0;
            pins_sync_reg <= 4'h0;
        end
        else
        begin
            pins_meta_reg <= pins_meta_next;
            pins_sync_reg <= pins_sync_next;
        end
    end

    logic uvlo_now;
    logic [1:0] select_now;

    assign uvlo_now = pins_sync_reg[3] | pins_sync_reg[2];
    assign select_now = pins_sync_reg[1:0];

    // ------------------------------------------------------------------
    // Register pointer
    // ------------------------------------------------------------------
    logic [7:0] pointer_reg;
    logic [7:0] pointer_next;

    // A pointer load wins over a data byte in the same cycle; the byte is not
    // written to any slot, and the pointer takes the loaded value, not a step.
    always_comb
    begin
        pointer_next = pointer_reg;
        if (uvlo_now)
        begin
            pointer_next = vid_profile_pkg::PTR_RESET;
        end
        else if (cmd_in.ptr_load)
        begin
            pointer_next = cmd_in.data;
        end
        else if (cmd_in.wr_en || cmd_in.rd_advance)
        begin
            pointer_next = 8'(pointer_reg + 8'h01);
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pointer_reg <= vid_profile_pkg::PTR_RESET;
        end
        else
        begin
            pointer_reg <= pointer_next;
        end
    end

    // ------------------------------------------------------------------
    // Profile slots
    // ------------------------------------------------------------------
    logic [3:0] slot_wr;
    vid_profile_pkg::profile_type slot_value [4];

    always_comb
    begin
        slot_wr = 4'h0;
        if (cmd_in.wr_en && !cmd_in.ptr_load)
        begin
            unique case (pointer_reg)
                vid_profile_pkg::PTR_PROFILE_A: slot_wr = 4'h1;
                vid_profile_pkg::PTR_PROFILE_B: slot_wr = 4'h2;
                vid_profile_pkg::PTR_PROFILE_C: slot_wr = 4'h4;
                vid_profile_pkg::PTR_PROFILE_D: slot_wr = 4'h8;
                default: slot_wr = 4'h0;
            endcase
        end
    end

    profile_slot #(.RESET_VALUE(vid_profile_pkg::RESET_PROFILE_A)) slot_a
    (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .uvlo_clear_in(uvlo_now),
        .wr_en_in(slot_wr[0]),
        .wr_data_in(cmd_in.data),
        .value_out(slot_value[0])
    );

    profile_slot #(.RESET_VALUE(vid_profile_pkg::RESET_PROFILE_B)) slot_b
    (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .uvlo_clear_in(uvlo_now),
        .wr_en_in(slot_wr[1]),
        .wr_data_in(cmd_in.data),
        .value_out(slot_value[1])
    );

    profile_slot #(.RESET_VALUE(vid_profile_pkg::RESET_PROFILE_C)) slot_c
    (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .uvlo_clear_in(uvlo_now),
        .wr_en_in(slot_wr[2]),
        .wr_data_in(cmd_in.data),
        .value_out(slot_value[2])
    );

    profile_slot #(.RESET_VALUE(vid_profile_pkg::RESET_PROFILE_D)) slot_d
    (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .uvlo_clear_in(uvlo_now),
        .wr_en_in(slot_wr[3]),
        .wr_data_in(cmd_in.data),
        .value_out(slot_value[3])
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    // The read byte always mirrors the register under the pointer one cycle
    // later, so the byte engine can load its shifter at any time.
    always_comb
    begin
        unique case (pointer_reg)
            vid_profile_pkg::PTR_PROFILE_A: rd_data_next = slot_value[0];
            vid_profile_pkg::PTR_PROFILE_B: rd_data_next = slot_value[1];
            vid_profile_pkg::PTR_PROFILE_C: rd_data_next = slot_value[2];
            vid_profile_pkg::PTR_PROFILE_D: rd_data_next = slot_value[3];
            default: rd_data_next = vid_profile_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_data_reg <= vid_profile_pkg::UNMAPPED_READ;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
        end
    end

    // ------------------------------------------------------------------
    // Active profile selection
    // ------------------------------------------------------------------
    vid_profile_pkg::slot_sel_type slot_sel_reg;
    vid_profile_pkg::slot_sel_type slot_sel_next;
    vid_profile_pkg::profile_type active_reg;
    vid_profile_pkg::profile_type active_next;

    // Select low is pin zero, select high is pin one.
    always_comb
    begin
        unique case (select_now)
            2'b00: slot_sel_next = vid_profile_pkg::SLOT_A;
            2'b01: slot_sel_next = vid_profile_pkg::SLOT_B;
            2'b10: slot_sel_next = vid_profile_pkg::SLOT_C;
            2'b11: slot_sel_next = vid_profile_pkg::SLOT_D;
        endcase
        active_next = slot_value[select_now];
    end

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            slot_sel_reg <= vid_profile_pkg::SLOT_A;
            active_reg <= vid_profile_pkg::RESET_PROFILE_A;
        end
        else
        begin
            slot_sel_reg <= slot_sel_next;
            active_reg <= active_next;
        end
    end

    assign rd_data_out = rd_data_reg;
    assign pointer_out = pointer_reg;
    assign active_profile_out = active_reg;
    assign active_slot_out = slot_sel_reg;
    assign uvlo_active_out = uvlo_now;

endmodule

// ===== vid_mode_voltage_regs_props.sv
`timescale 1ns/1ps

module vid_mode_voltage_regs_props
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input vid_profile_pkg::byte_cmd_type cmd_in,
    input wire logic profile_select_low_in,
    input wire logic profile_select_high_in,
    input wire logic vdd_uvlo_in,
    input wire logic main_power_input_uvlo_in,
    input wire logic [7:0] rd_data_out,
    input wire logic [7:0] pointer_out,
    input vid_profile_pkg::profile_type active_profile_out,
    input vid_profile_pkg::slot_sel_type active_slot_out,
    input wire logic uvlo_active_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);
    localparam logic [7:0] RST_TAB [4] = '{vid_profile_pkg::RESET_PROFILE_A, vid_profile_pkg::RESET_PROFILE_B,
        vid_profile_pkg::RESET_PROFILE_C, vid_profile_pkg::RESET_PROFILE_D};
    logic [1:0] pins;
    logic quiet;
    assign pins = {profile_select_high_in, profile_select_low_in};
    // Commands are only trusted while no supply is, or is about to be, in lockout.
    assign quiet = !uvlo_active_out && !vdd_uvlo_in && !main_power_input_uvlo_in;

    a_ptr_load_taken: assert property (cmd_in.ptr_load && quiet |=> pointer_out == $past(cmd_in.data))
        else $error("pointer load not taken");
    a_write_ptr_step: assert property (cmd_in.wr_en && !cmd_in.ptr_load && quiet
        |=> pointer_out == $past(pointer_out) + 8'h01) else $error("pointer did not step after write");
    a_read_ptr_step: assert property (cmd_in.rd_advance && !cmd_in.ptr_load && !cmd_in.wr_en && quiet
        |=> pointer_out == $past(pointer_out) + 8'h01) else $error("pointer did not step after read");
    a_slot_follows_pins: assert property ((quiet && $stable(pins))[*4]
        |-> active_slot_out == vid_profile_pkg::slot_sel_type'(pins)) else $error("wrong slot for pins");
    a_uvlo_detect: assert property ((vdd_uvlo_in || main_power_input_uvlo_in)[*3] |-> uvlo_active_out)
        else $error("lockout not seen");
    a_uvlo_profile_reset: assert property (uvlo_active_out[*3] ##0 $stable(active_slot_out)
        |-> active_profile_out == RST_TAB[active_slot_out]) else $error("profile not at reset in lockout");
    a_uvlo_ptr_reset: assert property (uvlo_active_out[*2] |-> pointer_out == vid_profile_pkg::PTR_RESET)
        else $error("pointer not reset in lockout");
    a_unmapped_zero: assert property (pointer_out > 8'h03 && $stable(pointer_out)
        |-> rd_data_out == vid_profile_pkg::UNMAPPED_READ) else $error("unmapped read not zero");
    a_write_shows: assert property ((cmd_in.wr_en && !cmd_in.ptr_load && quiet
        && pointer_out == {6'h00, active_slot_out}) ##1 (quiet && $stable(active_slot_out))[*2]
        |-> active_profile_out == $past(cmd_in.data, 2)) else $error("written profile not applied");

    c_back_to_back: cover property (cmd_in.wr_en ##1 cmd_in.wr_en);
    c_lockout: cover property (uvlo_active_out);
    c_slot_d: cover property (active_slot_out == vid_profile_pkg::SLOT_D);
endmodule

bind vid_mode_voltage_regs vid_mode_voltage_regs_props u_props (.clock_in, .nrst_in, .cmd_in,
    .profile_select_low_in, .profile_select_high_in, .vdd_uvlo_in, .main_power_input_uvlo_in,
    .rd_data_out, .pointer_out, .active_profile_out, .active_slot_out, .uvlo_active_out);

// ===== vid_profile_pkg.sv
package vid_profile_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PTR_W = 8;
    localparam int CODE_W = 6;
    localparam int SLOT_COUNT = 4;

    // ------------------------------------------------------------------
    // Register pointers
    // ------------------------------------------------------------------
    localparam logic [7:0] PTR_PROFILE_A = 8'h00;
    localparam logic [7:0] PTR_PROFILE_B = 8'h01;
    localparam logic [7:0] PTR_PROFILE_C = 8'h02;
    localparam logic [7:0] PTR_PROFILE_D = 8'h03;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_PROFILE_A = 8'hB4;
    localparam logic [7:0] RESET_PROFILE_B = 8'h1E;
    localparam logic [7:0] RESET_PROFILE_C = 8'hB0;
    localparam logic [7:0] RESET_PROFILE_D = 8'h9E;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------------
    // Field positions inside a profile register
    // ------------------------------------------------------------------
    localparam int BIT_FORCED_PWM = 7;
    localparam int BIT_CLOCK_LOCK_EN = 6;
    localparam int VOLTAGE_CODE_MSB = 5;
    localparam int VOLTAGE_CODE_LSB = 0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic forced_pwm;
        logic clock_lock_en;
        logic [CODE_W-1:0] voltage_code;
    } profile_type;

    typedef struct packed {
        logic ptr_load;
        logic wr_en;
        logic rd_advance;
        logic [DATA_W-1:0] data;
    } byte_cmd_type;

    typedef enum logic [1:0] {
        SLOT_A,
        SLOT_B,
        SLOT_C,
        SLOT_D
    } slot_sel_type;

endpackage
